// ### bench/mcu_interrupt_priority_vectoring_tb_top.sv
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch %0t %h %h", $time, (a), (b)); end end

module mcu_interrupt_priority_vectoring_tb_top import mipv_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic ref_clk = 1'h0;
  logic rst_n, hsel, hwrite, hreadyout, hresp, modeA, modeB;
  logic irqReqN, xirqReqN, clkFailReq, wdogReq, illegalOp, swiFetch;
  logic instrBoundary, firstHandlerDone, flagsWrite, flagsWriteX;
  logic flagsWriteI, flagsReturn, returnX, returnI, vecValid, go;
  logic stackX, stackI, xMask, iMask, bootRomEn;
  logic [31:0]        haddr, hwdata, hrdata, q;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [NUM_SRC-1:0] periphReq;
  logic [15:0]        vecAddr, tv;
  logic [7:0]         cnt;
  int                 mismatches, checks;

  mipv_vector_core #(.PRD_BASE(8)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .modeA(modeA), .modeB(modeB),
    .irqReqN(irqReqN), .xirqReqN(xirqReqN), .periphReq(periphReq),
    .clkFailReq(clkFailReq), .wdogReq(wdogReq), .illegalOp(illegalOp),
    .swiFetch(swiFetch), .instrBoundary(instrBoundary),
    .firstHandlerDone(firstHandlerDone), .flagsWrite(flagsWrite),
    .flagsWriteX(flagsWriteX), .flagsWriteI(flagsWriteI),
    .flagsReturn(flagsReturn), .returnX(returnX), .returnI(returnI),
    .vecValid(vecValid), .vecAddr(vecAddr), .stackX(stackX),
    .stackI(stackI), .xMask(xMask), .iMask(iMask), .bootRomEn(bootRomEn));

  mipv_cpu_model cpu (.ref_clk(ref_clk), .go(go), .vecValid(vecValid),
    .vecAddr(vecAddr), .instrBoundary(instrBoundary), .tookVec_reg(tv),
    .tookCnt_reg(cnt));

  // Clock
  always #2 ref_clk = ~ref_clk;
  // ------------------------------------------------------------
  // Bus and sequencer tasks
  // ------------------------------------------------------------
  task automatic print_verdict;
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic rdy;
    int n;
    n = 0;
    do begin @(posedge ref_clk); n++; end
    while (hreadyout !== 1'h1 && n < 16);
    if (n >= 16) begin mismatches++; print_verdict(); end
    `CHK(hresp, HRESP_OKAY)
  endtask : rdy

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'h1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    rdy();
    hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
    rdy();
    q = hrdata;
  endtask : bus

  task automatic take(input logic [15:0] v, input logic exp);
    logic [7:0] c0;
    int         n;
    c0 = cnt;
    n = 0;
    go <= 1'h1;
    @(posedge ref_clk);
    go <= 1'h0;
    while (cnt === c0 && n < 8) begin @(posedge ref_clk); n++; end
    if (exp && n >= 8) begin mismatches++; print_verdict(); end
    if (exp) `CHK(tv, v)
    else `CHK(cnt, c0)
  endtask : take

  // Flags transfer (r=0) or return (r=1) with X and I values
  task automatic cc(input logic r, input logic x, input logic i);
    flagsReturn <= r; flagsWrite <= !r; returnX <= x; returnI <= i;
    flagsWriteX <= x; flagsWriteI <= i;
    @(posedge ref_clk);
    flagsReturn <= 1'h0; flagsWrite <= 1'h0;
    repeat (2) @(posedge ref_clk);
  endtask : cc
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic sReset(input logic a, input logic b,
                        input logic [15:0] v, input logic boot);
    modeA <= a; modeB <= b; rst_n <= 1'h0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge ref_clk);
    `CHK({xMask, iMask}, 2'h3)
    take(v, 1'h1);
    `CHK(bootRomEn, boot)
    bus(1'h0, ADDR_PERIODIC, 32'h0);
    `CHK(q[PRD_FLAG_BIT], 1'h0)
    repeat (2) @(posedge ref_clk);
    bus(1'h0, ADDR_PERIODIC, 32'h0);
    `CHK(q[PRD_FLAG_BIT], 1'h1)
  endtask : sReset

  task automatic sPrio;
    bus(1'h0, ADDR_PRIO, 32'h0);
    `CHK(q[4:0], PSEL_RESET)
    bus(1'h1, ADDR_ENABLE, 32'h0000_0024);
    bus(1'h1, ADDR_PRIO, 32'h0000_000B);
    cc(1'h0, 1'h0, 1'h0);
    bus(1'h1, ADDR_PRIO, 32'h0000_0006);
    bus(1'h0, ADDR_PRIO, 32'h0);
    `CHK({q[4:0], xMask, iMask}, 7'h2C)
    periphReq <= 20'h00024;
    take(VEC_TABLE[5], 1'h1);
    `CHK({stackX, stackI, xMask, iMask}, 4'h1)
    cc(1'h1, 1'h0, 1'h0);
    xirqReqN <= 1'h0;
    take(VEC_NONMASKABLE_REQUEST_PIN, 1'h1);
    `CHK({stackX, xMask, iMask}, 3'h3)
    xirqReqN <= 1'h1;
    cc(1'h1, 1'h0, 1'h0);
    `CHK({xMask, iMask}, 2'h0)
    cc(1'h0, 1'h1, 1'h0);
    `CHK(xMask, 1'h0)
    bus(1'h1, ADDR_ENABLE, 32'h0000_0004);
    take(VEC_TABLE[2], 1'h1);
    periphReq <= 20'h0;
    bus(1'h1, ADDR_PERIODIC, 32'h0000_0001);
    cc(1'h1, 1'h0, 1'h0);
    take(VEC_TABLE[1], 1'h1);
    bus(1'h1, ADDR_PERIODIC, 32'h0000_0100);
  endtask : sPrio

  task automatic sTrap;
    cc(1'h1, 1'h0, 1'h0);
    swiFetch <= 1'h1;
    @(posedge ref_clk);
    swiFetch <= 1'h0;
    take(VEC_SWI, 1'h1);
    `CHK(iMask, 1'h1)
    xirqReqN <= 1'h0;
    take(16'h0000, 1'h0);
    firstHandlerDone <= 1'h1;
    @(posedge ref_clk);
    firstHandlerDone <= 1'h0;
    take(VEC_NONMASKABLE_REQUEST_PIN, 1'h1);
    xirqReqN <= 1'h1;
    illegalOp <= 1'h1;
    @(posedge ref_clk);
    illegalOp <= 1'h0;
    take(VEC_ILLEGAL, 1'h1);
    clkFailReq <= 1'h1;
    wdogReq <= 1'h1;
    take(VEC_CLKFAIL, 1'h1);
    clkFailReq <= 1'h0;
    take(VEC_WDOG, 1'h1);
    wdogReq <= 1'h0;
  endtask : sTrap

  // Main sequence
  initial begin
    rst_n = 1'h0; hsel = 1'h0; hwrite = 1'h0;
    haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; hsize = HSIZE_WORD;
    modeA = 1'h0; modeB = 1'h1; irqReqN = 1'h1; xirqReqN = 1'h1;
    periphReq = 20'h0; clkFailReq = 1'h0; wdogReq = 1'h0;
    illegalOp = 1'h0; swiFetch = 1'h0; firstHandlerDone = 1'h0;
    flagsWrite = 1'h0; flagsWriteX = 1'h0; flagsWriteI = 1'h0;
    flagsReturn = 1'h0; returnX = 1'h0; returnI = 1'h0; go = 1'h0;
    mismatches = 0; checks = 0;
    sReset(1'h0, 1'h0, 16'hBFFE, 1'h1);
    sReset(1'h1, 1'h0, 16'hBFFE, 1'h0);
    sReset(1'h1, 1'h1, VEC_RESET, 1'h0);
    sReset(1'h0, 1'h1, VEC_RESET, 1'h0);
    sPrio();
    sTrap();
    print_verdict();
  end
endmodule : mcu_interrupt_priority_vectoring_tb_top

// ### bench/mipv_cpu_model.sv
module mipv_cpu_model (
  input  wire logic        ref_clk,
  input  wire logic        go,
  input  wire logic        vecValid,
  input  wire logic [15:0] vecAddr,
  output logic             instrBoundary,
  output logic [15:0]      tookVec_reg,
  output logic [7:0]       tookCnt_reg
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet at time zero, then boundary pulses and vector capture
  initial begin
    instrBoundary = 1'h0;
    tookVec_reg = 16'h0000;
    tookCnt_reg = 8'h00;
    forever begin
      @(posedge ref_clk);
      instrBoundary <= go;
      if (vecValid === 1'h1) begin
        tookVec_reg <= vecAddr;
        tookCnt_reg <= tookCnt_reg + 8'h01;
      end
    end
  end
endmodule : mipv_cpu_model

// ### hdl/mipv_periodic_timer.sv
module mipv_periodic_timer import mipv_pkg::*; #(
  parameter int PRD_BASE = PRD_BASE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  mipv_prd_if.tmr  prd
);

  logic [PRD_CNT_W-1:0] cnt_reg;
  logic [PRD_CNT_W-1:0] cnt_next;
  logic                 tick_reg;
  logic                 tick_next;
  logic [PRD_CNT_W-1:0] periodCyc;
  logic [2:0]           rateEff;

  // ----------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------
  // Counts a full period from reset before the first tick
  always_comb begin
    rateEff   = (prd.rate > PRD_RATE_MAX) ? PRD_RATE_MAX : prd.rate;
    periodCyc = PRD_CNT_W'(PRD_BASE) << rateEff;
    tick_next = 1'b0;
    cnt_next  = cnt_reg + 1'b1;
    if (cnt_reg >= periodCyc - 1'b1) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end
  end

  // Counter registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign prd.tick = tick_reg;

endmodule : mipv_periodic_timer

// ### hdl/mipv_pkg.sv
package mipv_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SRC   = 20;
  localparam int IDX_W     = 5;
  localparam int ADDR_W    = 8;
  localparam int PRD_CNT_W = 24;

  // ----------------------------------------------------------------
  // Register map and bus constants
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_PRIO     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE   = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PERIODIC = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h0C;
  localparam logic [2:0]        HSIZE_WORD    = 3'h2;
  localparam logic              HRESP_OKAY    = 1'h0;

  // Field positions
  localparam int PRIO_MODE_LSB  = 5;
  localparam int PRD_EN_BIT     = 0;
  localparam int PRD_RATE_LSB   = 1;
  localparam int PRD_FLAG_BIT   = 8;
  localparam int STAT_I_BIT     = 0;
  localparam int STAT_X_BIT     = 1;
  localparam int STAT_GUARD_BIT = 2;
  localparam int STAT_WIN_LSB   = 3;
  localparam int STAT_KIND_LSB  = 8;
  localparam int STAT_PEND_LSB  = 12;

  // Reset values and rate limit
  localparam logic [4:0]         PSEL_RESET     = 5'h06;
  localparam logic [NUM_SRC-1:0] ENABLE_RESET   = 20'h00000;
  localparam logic [2:0]         PRD_RATE_RESET = 3'h0;
  localparam logic [2:0]         PRD_RATE_MAX   = 3'h5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 250;
  localparam int PRD_BASE_US  = 32;
  localparam int PRD_BASE_CYC = PRD_BASE_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Vectors (index order equals fixed maskable rank order)
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_RESET     = 16'hFFFE;
  localparam logic [15:0] VEC_CLKFAIL   = 16'hFFFC;
  localparam logic [15:0] VEC_WDOG      = 16'hFFFA;
  localparam logic [15:0] VEC_ILLEGAL   = 16'hFFF8;
  localparam logic [15:0] VEC_SWI       = 16'hFFF6;
  localparam logic [15:0] VEC_NONMASKABLE_REQUEST_PIN      = 16'hFFF4;
  localparam logic [15:0] VEC_BOOT_MASK = 16'hBFFF;

  localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
    16'hFFF2, 16'hFFF0, 16'hFFEE, 16'hFFEC, 16'hFFEA,
    16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFE0,
    16'hFFD4, 16'hFFD2, 16'hFFDE, 16'hFFD0, 16'hFFDC,
    16'hFFDA, 16'hFFCE, 16'hFFCC, 16'hFFD8, 16'hFFD6};

  localparam logic [4:0] PSEL_TABLE [NUM_SRC] = '{
    5'h06, 5'h07, 5'h08, 5'h09, 5'h0A,
    5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F,
    5'h15, 5'h16, 5'h10, 5'h17, 5'h11,
    5'h12, 5'h18, 5'h19, 5'h13, 5'h14};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SINGLE, MODE_EXPANDED, MODE_BOOT, MODE_TEST
  } mipv_mode_t;

  typedef enum logic [2:0] {
    KIND_NONE, KIND_RESET, KIND_CLKFAIL, KIND_WDOG,
    KIND_ILLEGAL, KIND_SWI, KIND_NONMASKABLE_REQUEST_PIN, KIND_MASKABLE
  } mipv_kind_t;

  typedef enum logic {ST_RUN, ST_GUARD} mipv_state_t;

endpackage : mipv_pkg

// ### hdl/mipv_prd_if.sv
interface mipv_prd_if;
  logic [2:0] rate;
  logic       tick;
  modport ctl (output rate, input tick);
  modport tmr (input rate, output tick);
endinterface : mipv_prd_if

// ### hdl/mipv_vector_core.sv
module mipv_vector_core import mipv_pkg::*; #(
  parameter int PRD_BASE = PRD_BASE_CYC
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic               modeA,
  input  wire logic               modeB,
  input  wire logic               irqReqN,
  input  wire logic               xirqReqN,
  input  wire logic [NUM_SRC-1:0] periphReq,
  input  wire logic               clkFailReq,
  input  wire logic               wdogReq,
  input  wire logic               illegalOp,
  input  wire logic               swiFetch,
  input  wire logic               instrBoundary,
  input  wire logic               firstHandlerDone,
  input  wire logic               flagsWrite,
  input  wire logic               flagsWriteX,
  input  wire logic               flagsWriteI,
  input  wire logic               flagsReturn,
  input  wire logic               returnX,
  input  wire logic               returnI,
  output logic                    vecValid,
  output logic      [15:0]        vecAddr,
  output logic                    stackX,
  output logic                    stackI,
  output logic                    xMask,
  output logic                    iMask,
  output logic                    bootRomEn
);

  mipv_mode_t         modeSel_reg, modeSel_next;
  logic               strapDone_reg, strapDone_next;
  logic [ADDR_W-1:0]  busAddr_reg, busAddr_next;
  logic               busWr_reg, busWr_next;
  logic [31:0]        hrdata_reg, hrdata_next;
  logic [4:0]         psel_reg, psel_next;
  logic [NUM_SRC-1:0] enable_reg, enable_next;
  logic               prdEn_reg, prdEn_next;
  logic [2:0]         prdRate_reg, prdRate_next;
  logic               prdFlag_reg, prdFlag_next;
  logic               xMask_reg, xMask_next;
  logic               iMask_reg, iMask_next;
  logic               resetPend_reg, resetPend_next;
  logic               illegalPend_reg, illegalPend_next;
  logic               swiPend_reg, swiPend_next;
  mipv_state_t        state_reg, state_next;
  logic               vecValid_reg, vecValid_next;
  logic [15:0]        vecAddr_reg, vecAddr_next;
  logic               stackX_reg, stackX_next;
  logic               stackI_reg, stackI_next;
  logic [IDX_W-1:0]   lastIdx_reg, lastIdx_next;
  mipv_kind_t         lastKind_reg, lastKind_next;
  logic [NUM_SRC-1:0] rawReq;
  logic [NUM_SRC-1:0] localEn;
  logic [NUM_SRC-1:0] pending;
  logic [IDX_W-1:0]   promIdx;
  logic [IDX_W-1:0]   winIdx;
  mipv_kind_t         kind;
  logic [15:0]        vecRaw;
  logic               take;
  logic               bootArea;

  mipv_prd_if prd ();

  // ----------------------------------------------------------------
  // Periodic timer
  // ----------------------------------------------------------------
  assign prd.rate = prdRate_reg;

  mipv_periodic_timer #(.PRD_BASE(PRD_BASE)) uTimer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .prd     (prd.tmr)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Map priority code to source index, reserved codes to external
  function automatic logic [IDX_W-1:0] promoteIdx(input logic [4:0] code);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int k = 0; k < NUM_SRC; k++) begin
      if (PSEL_TABLE[k] == code) begin
        idx = IDX_W'(k);
      end
    end
    return idx;
  endfunction : promoteIdx

  // Register read multiplexer
  function automatic logic [31:0] readWord(input logic [31:0] addr);
    logic [31:0] d;
    d = 32'h00000000;
    if (addr[31:4] == 28'h0000000) begin
      case (addr[ADDR_W-1:0])
        ADDR_PRIO: begin
          d[4:0] = psel_reg;
          d[PRIO_MODE_LSB +: 2] = modeSel_reg;
        end
        ADDR_ENABLE: d[NUM_SRC-1:0] = localEn;
        ADDR_PERIODIC: begin
          d[PRD_EN_BIT]        = prdEn_reg;
          d[PRD_RATE_LSB +: 3] = prdRate_reg;
          d[PRD_FLAG_BIT]      = prdFlag_reg;
        end
        ADDR_STATUS: begin
          d[STAT_I_BIT]           = iMask_reg;
          d[STAT_X_BIT]           = xMask_reg;
          d[STAT_GUARD_BIT]       = (state_reg == ST_GUARD);
          d[STAT_WIN_LSB +: 5]    = lastIdx_reg;
          d[STAT_KIND_LSB +: 3]   = lastKind_reg;
          d[STAT_PEND_LSB +: 20]  = pending;
        end
        default: d = 32'h00000000;
      endcase
    end
    return d;
  endfunction : readWord

  // ----------------------------------------------------------------
  // Mode strap
  // ----------------------------------------------------------------
  // Mode pins caught at the first edge after reset release
  always_comb begin
    strapDone_next = 1'b1;
    modeSel_next   = modeSel_reg;
    if (!strapDone_reg) begin
      case ({modeA, modeB})
        2'b01:   modeSel_next = MODE_SINGLE;
        2'b11:   modeSel_next = MODE_EXPANDED;
        2'b00:   modeSel_next = MODE_BOOT;
        default: modeSel_next = MODE_TEST;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strapDone_reg <= 1'b0;
      modeSel_reg   <= MODE_SINGLE;
    end else begin
      strapDone_reg <= strapDone_next;
      modeSel_reg   <= modeSel_next;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave and registers
  // ----------------------------------------------------------------
  // Address phase capture, zero wait state, read data registered
  always_comb begin
    busAddr_next = busAddr_reg;
    busWr_next   = 1'b0;
    hrdata_next  = 32'h00000000;
    if (hsel && hready && htrans[1]) begin
      busAddr_next = haddr[ADDR_W-1:0];
      busWr_next   = hwrite && (hsize == HSIZE_WORD)
                     && (haddr[31:4] == 28'h0000000);
      if (!hwrite) begin
        hrdata_next = readWord(haddr);
      end
    end
  end

  // Software registers; hardware flag set wins over clear
  always_comb begin
    psel_next    = psel_reg;
    enable_next  = enable_reg;
    prdEn_next   = prdEn_reg;
    prdRate_next = prdRate_reg;
    prdFlag_next = prdFlag_reg;
    if (busWr_reg) begin
      case (busAddr_reg)
        ADDR_PRIO: begin
          if (iMask_reg) begin
            psel_next = hwdata[4:0];
          end
        end
        ADDR_ENABLE: enable_next = hwdata[NUM_SRC-1:0];
        ADDR_PERIODIC: begin
          prdEn_next   = hwdata[PRD_EN_BIT];
          prdRate_next = hwdata[PRD_RATE_LSB +: 3];
          if (hwdata[PRD_FLAG_BIT]) begin
            prdFlag_next = 1'b0;
          end
        end
        default: psel_next = psel_reg;
      endcase
    end
    if (prd.tick) begin
      prdFlag_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busAddr_reg <= '0;
      busWr_reg   <= 1'b0;
      hrdata_reg  <= 32'h00000000;
      psel_reg    <= PSEL_RESET;
      enable_reg  <= ENABLE_RESET;
      prdEn_reg   <= 1'b0;
      prdRate_reg <= PRD_RATE_RESET;
      prdFlag_reg <= 1'b0;
    end else begin
      busAddr_reg <= busAddr_next;
      busWr_reg   <= busWr_next;
      hrdata_reg  <= hrdata_next;
      psel_reg    <= psel_next;
      enable_reg  <= enable_next;
      prdEn_reg   <= prdEn_next;
      prdRate_reg <= prdRate_next;
      prdFlag_reg <= prdFlag_next;
    end
  end

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  // Gate each maskable source, promote one, pick the winner
  always_comb begin
    rawReq    = periphReq;
    rawReq[0] = !irqReqN;
    rawReq[1] = prdFlag_reg;
    localEn    = enable_reg;
    localEn[0] = 1'b1;
    localEn[1] = prdEn_reg;
    pending = rawReq & localEn & {NUM_SRC{!iMask_reg}};
    promIdx = promoteIdx(psel_reg);
    winIdx  = '0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (pending[k]) begin
        winIdx = IDX_W'(k);
      end
    end
    if (pending[promIdx]) begin
      winIdx = promIdx;
    end
    kind = KIND_NONE;
    if (resetPend_reg) begin
      kind = KIND_RESET;
    end else if (clkFailReq) begin
      kind = KIND_CLKFAIL;
    end else if (wdogReq) begin
      kind = KIND_WDOG;
    end else if (state_reg == ST_GUARD) begin
      kind = KIND_NONE;
    end else if (illegalPend_reg) begin
      kind = KIND_ILLEGAL;
    end else if (swiPend_reg) begin
      kind = KIND_SWI;
    end else if (!xirqReqN && !xMask_reg) begin
      kind = KIND_NONMASKABLE_REQUEST_PIN;
    end else if (|pending) begin
      kind = KIND_MASKABLE;
    end
    case (kind)
      KIND_RESET:   vecRaw = VEC_RESET;
      KIND_CLKFAIL: vecRaw = VEC_CLKFAIL;
      KIND_WDOG:    vecRaw = VEC_WDOG;
      KIND_ILLEGAL: vecRaw = VEC_ILLEGAL;
      KIND_SWI:     vecRaw = VEC_SWI;
      KIND_NONMASKABLE_REQUEST_PIN:    vecRaw = VEC_NONMASKABLE_REQUEST_PIN;
      default:      vecRaw = VEC_TABLE[winIdx];
    endcase
    bootArea = (modeSel_reg == MODE_BOOT) || (modeSel_reg == MODE_TEST);
    take     = instrBoundary && (kind != KIND_NONE);
  end

  // ----------------------------------------------------------------
  // Entry, return and mask flags
  // ----------------------------------------------------------------
  // Entry beats return, return beats a flags transfer
  always_comb begin
    xMask_next       = xMask_reg;
    iMask_next       = iMask_reg;
    stackX_next      = stackX_reg;
    stackI_next      = stackI_reg;
    vecValid_next    = take;
    vecAddr_next     = vecAddr_reg;
    lastIdx_next     = lastIdx_reg;
    lastKind_next    = lastKind_reg;
    resetPend_next   = resetPend_reg && !(take && kind == KIND_RESET);
    illegalPend_next = illegalOp
                       || (illegalPend_reg && !(take && kind == KIND_ILLEGAL));
    swiPend_next     = swiFetch
                       || (swiPend_reg && !(take && kind == KIND_SWI));
    state_next       = state_reg;
    if (take) begin
      stackX_next   = xMask_reg;
      stackI_next   = iMask_reg;
      vecAddr_next  = bootArea ? (vecRaw & VEC_BOOT_MASK) : vecRaw;
      lastIdx_next  = winIdx;
      lastKind_next = kind;
      iMask_next    = 1'b1;
      case (kind)
        KIND_RESET, KIND_CLKFAIL, KIND_WDOG, KIND_NONMASKABLE_REQUEST_PIN: begin
          xMask_next = 1'b1;
        end
        default: xMask_next = xMask_reg;
      endcase
    end else if (flagsReturn) begin
      xMask_next = returnX;
      iMask_next = returnI;
    end else if (flagsWrite && !resetPend_reg) begin
      xMask_next = xMask_reg && flagsWriteX;
      iMask_next = flagsWriteI;
    end
    case (state_reg)
      ST_RUN: begin
        if (take && (kind == KIND_SWI || kind == KIND_ILLEGAL)) begin
          state_next = ST_GUARD;
        end
      end
      ST_GUARD: begin
        if (firstHandlerDone || take) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      xMask_reg       <= 1'b1;
      iMask_reg       <= 1'b1;
      stackX_reg      <= 1'b0;
      stackI_reg      <= 1'b0;
      vecValid_reg    <= 1'b0;
      vecAddr_reg     <= 16'h0000;
      lastIdx_reg     <= '0;
      lastKind_reg    <= KIND_NONE;
      resetPend_reg   <= 1'b1;
      illegalPend_reg <= 1'b0;
      swiPend_reg     <= 1'b0;
      state_reg       <= ST_RUN;
    end else begin
      xMask_reg       <= xMask_next;
      iMask_reg       <= iMask_next;
      stackX_reg      <= stackX_next;
      stackI_reg      <= stackI_next;
      vecValid_reg    <= vecValid_next;
      vecAddr_reg     <= vecAddr_next;
      lastIdx_reg     <= lastIdx_next;
      lastKind_reg    <= lastKind_next;
      resetPend_reg   <= resetPend_next;
      illegalPend_reg <= illegalPend_next;
      swiPend_reg     <= swiPend_next;
      state_reg       <= state_next;
    end
  end

  // Outputs
  assign hrdata    = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign vecValid  = vecValid_reg;
  assign vecAddr   = vecAddr_reg;
  assign stackX    = stackX_reg;
  assign stackI    = stackI_reg;
  assign xMask     = xMask_reg;
  assign iMask     = iMask_reg;
  assign bootRomEn = (modeSel_reg == MODE_BOOT);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seqTrapTaken;
    take && (kind == KIND_SWI || kind == KIND_ILLEGAL);
  endsequence

  sequence seqNoResetClass;
    !clkFailReq && !wdogReq;
  endsequence

  vec_boot_a: assert property (vecValid_reg && bootArea
    |-> vecAddr_reg[15:6] == 10'h2FF) else $error("vector outside boot area");
  vec_norm_a: assert property (vecValid_reg && !bootArea
    |-> vecAddr_reg[15:6] == 10'h3FF) else $error("vector outside top area");
  prio_lock_a: assert property (busWr_reg && busAddr_reg == ADDR_PRIO
    && !iMask_reg |=> $stable(psel_reg)) else $error("priority changed");
  imask_entry_a: assert property (take && kind == KIND_MASKABLE
    |=> iMask_reg && stackI_reg == $past(iMask_reg)
    && xMask_reg == $past(xMask_reg)) else $error("I entry masks wrong");
  nonmaskable_request_pin_entry_a: assert property (take && kind == KIND_NONMASKABLE_REQUEST_PIN
    |=> xMask_reg && iMask_reg && !stackX_reg) else $error("X entry wrong");
  xset_block_a: assert property (!xMask_reg && !take && !flagsReturn
    |=> !xMask_reg) else $error("X set by software");
  reset_mask_a: assert property (resetPend_reg
    |-> xMask_reg && iMask_reg) else $error("masks clear before reset vector");
  trap_guard_a: assert property (seqTrapTaken ##1 seqNoResetClass
    |=> !vecValid_reg) else $error("source served inside trap guard");
  nmi_wins_a: assert property (take && kind == KIND_MASKABLE
    |-> xirqReqN || xMask_reg) else $error("maskable beat nonmaskable pin");
  promote_a: assert property (take && kind == KIND_MASKABLE
    && pending[promIdx] |=> lastIdx_reg == $past(promIdx))
    else $error("promoted source lost");

endmodule : mipv_vector_core
